// ### diag_flag_cell.sv
// Shared constants and the single latched flag cell
`timescale 1ns/100ps

package diag_flag_pkg;
  localparam int FLAG_COUNT = 22;
  // Flag positions
  localparam int F_CANL_BAT = 0;
  localparam int F_CANL_VDD = 1;
  localparam int F_CANL_GND = 2;
  localparam int F_CANH_BAT = 3;
  localparam int F_CANH_VDD = 4;
  localparam int F_CANH_GND = 5;
  localparam int F_HS3_GND = 6;
  localparam int F_HS2_GND = 7;
  localparam int F_PARITY = 8;
  localparam int F_SEL_STUCK = 9;
  localparam int F_SUP2_UNDER = 10;
  localparam int F_SUP1_OVER = 11;
  localparam int F_IO0_THERMAL = 12;
  localparam int F_WD_HALF = 13;
  localparam int F_WAKE_IO13 = 14;
  localparam int F_WAKE_IO02 = 15;
  localparam int F_WAKE_SERIAL = 16;
  localparam int F_WAKE_FORCED = 17;
  localparam int F_INT_TIMEOUT = 18;
  localparam int F_LP_OFF = 19;
  localparam int F_RESET_REQ = 20;
  localparam int F_DEBUG_EXIT = 21;
  // Flags that also wait for the condition to recover before clearing
  localparam logic [FLAG_COUNT-1:0] HOLD_MASK = 22'h001CFF;
  localparam logic [FLAG_COUNT-1:0] FLAGS_RESET = 22'h000000;
  // Timing
  localparam int CLK_FREQ_KHZ = 50000;
  localparam int SELECT_STUCK_US = 2000;
  localparam int SELECT_STUCK_CYC = (SELECT_STUCK_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int WD_WIDTH = 16;
endpackage

module diag_flag_cell
  import diag_flag_pkg::*;
#(
  parameter bit HOLD = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Source
  input wire logic set_in,
  input wire logic cond_in,
  // Host read
  input wire logic read_clr,
  // Flag
  output logic flag
);

  typedef struct packed {
    logic flag;
    logic read_seen;
  } cell_s;

  cell_s state_q, state_d;

  always_comb begin
    state_d = state_q;
    if (set_in) begin
      state_d.flag = 1'b1;
    end else if (HOLD) begin
      if (state_q.flag && (state_q.read_seen || read_clr) && !cond_in) begin
        state_d.flag = 1'b0;
      end
    end else if (read_clr) begin
      state_d.flag = 1'b0;
    end
    if (read_clr && state_q.flag) begin
      state_d.read_seen = 1'b1;
    end
    if (!state_d.flag) begin
      state_d.read_seen = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flag = state_q.flag;

endmodule

// ### diag_fault_wake_flags.sv
// Latched diagnostic, fault and wake-source flags read and cleared by the host
`timescale 1ns/100ps

// Summary of operation
// - Six CAN wire short flags, set on fault
// - Fault flags clear after recovery and host read
// - Separate high-side short flags, channels two, three
// - Parity error flag, read clears
// - Select low too long sets flag, read clears
// - Supply two undervoltage, clears recovered and read
// - Supply one overvoltage, clears recovered and read
// - Channel zero thermal, clears cooled and read
// - Flash mode watchdog past half sets flag
// - Wake on channel one or three flag
// - Wake on channel zero or two flag
// - Serial wake from regulator-on low power
// - Forced timer wake flag, read clears
// - Interrupt service timeout flag, read clears
// - Regulator-off low power before wake recorded
// - Serial reset request source flag
// - Hardware debug exit flag, read clears
module diag_fault_wake_flags
  import diag_flag_pkg::*;
#(
  parameter int STUCK_CYCLES = SELECT_STUCK_CYC,
  parameter int WD_W = WD_WIDTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // CAN wire short detectors, high while the fault stands
  input wire logic canl_short_bat,
  input wire logic canl_short_vdd,
  input wire logic canl_short_gnd,
  input wire logic canh_short_bat,
  input wire logic canh_short_vdd,
  input wire logic canh_short_gnd,
  // High-side switch short detectors
  input wire logic high_side_switch3_short_gnd,
  input wire logic high_side_switch2_short_gnd,
  // Serial port
  input wire logic serial_select_n,
  input wire logic parity_error_evt,
  // Supply and thermal detectors, levels
  input wire logic supply_two_under_threshold,
  input wire logic supply_over_threshold,
  input wire logic io0_thermal_over,
  // Watchdog
  input wire logic flash_mode,
  input wire logic [WD_W-1:0] wd_elapsed,
  input wire logic [WD_W-1:0] wd_period,
  // Wake and reset events, one-cycle pulses; low-power modes, levels
  input wire logic io1_wake_evt,
  input wire logic io3_wake_evt,
  input wire logic io0_wake_evt,
  input wire logic io2_wake_evt,
  input wire logic serial_wake_evt,
  input wire logic lowpower_regulator_on_mode,
  input wire logic lowpower_regulator_off_mode,
  input wire logic forced_wake_event,
  input wire logic int_timeout_evt,
  input wire logic serial_reset_evt,
  // Debug
  input wire logic debug_mode,
  input wire logic debug_entry_pin,
  // Host read
  input wire logic [FLAG_COUNT-1:0] read_sel,
  input wire logic read_capture,
  input wire logic read_done,
  // Results
  output logic [FLAG_COUNT-1:0] read_data,
  output logic [FLAG_COUNT-1:0] flags
);

  localparam int CNT_W = $clog2(STUCK_CYCLES + 1);

  if (STUCK_CYCLES < 1) begin : g_bad_stuck
    $error("STUCK_CYCLES must be at least one");
  end
  if (WD_W < 2) begin : g_bad_wd
    $error("WD_W must be at least two");
  end

  typedef struct packed {
    logic [CNT_W-1:0] sel_cnt;
    logic wd_half_prev;
    logic debug_pin_prev;
    logic [FLAG_COUNT-1:0] snap;
  } top_s;

  top_s state_q, state_d;
  logic [FLAG_COUNT-1:0] set_vec;
  logic [FLAG_COUNT-1:0] cond_vec;
  logic [FLAG_COUNT-1:0] clr_vec;
  logic wd_half;
  logic sel_stuck_evt;
  logic any_wake;

  // Past half when twice the elapsed count exceeds the period
  function automatic logic past_half(input logic [WD_W-1:0] elapsed,
                                     input logic [WD_W-1:0] period);
    past_half = {elapsed, 1'b0} > {1'b0, period};
  endfunction

  always_comb begin
    state_d = state_q;
    wd_half = flash_mode && past_half(wd_elapsed, wd_period);
    state_d.wd_half_prev = wd_half;
    // Saturating count, so one long low period gives one event only
    sel_stuck_evt = 1'b0;
    if (serial_select_n) begin
      state_d.sel_cnt = '0;
    end else if (state_q.sel_cnt != CNT_W'(STUCK_CYCLES)) begin
      state_d.sel_cnt = state_q.sel_cnt + CNT_W'(1);
      if (state_q.sel_cnt == CNT_W'(STUCK_CYCLES - 1)) begin
        sel_stuck_evt = 1'b1;
      end
    end
    state_d.debug_pin_prev = debug_entry_pin;
    // Snapshot holds the pre-clear value until the transfer ends
    if (read_capture) begin
      state_d.snap = flags & read_sel;
    end else if (read_done) begin
      state_d.snap = '0;
    end
  end

  assign any_wake = io0_wake_evt | io1_wake_evt | io2_wake_evt | io3_wake_evt |
                    serial_wake_evt | forced_wake_event;

  always_comb begin
    cond_vec = '0;
    cond_vec[F_CANL_BAT] = canl_short_bat;
    cond_vec[F_CANL_VDD] = canl_short_vdd;
    cond_vec[F_CANL_GND] = canl_short_gnd;
    cond_vec[F_CANH_BAT] = canh_short_bat;
    cond_vec[F_CANH_VDD] = canh_short_vdd;
    cond_vec[F_CANH_GND] = canh_short_gnd;
    cond_vec[F_HS3_GND] = high_side_switch3_short_gnd;
    cond_vec[F_HS2_GND] = high_side_switch2_short_gnd;
    cond_vec[F_SUP2_UNDER] = supply_two_under_threshold;
    cond_vec[F_SUP1_OVER] = supply_over_threshold;
    cond_vec[F_IO0_THERMAL] = io0_thermal_over;
    set_vec = cond_vec & HOLD_MASK;
    set_vec[F_PARITY] = parity_error_evt;
    set_vec[F_SEL_STUCK] = sel_stuck_evt;
    set_vec[F_WD_HALF] = wd_half && !state_q.wd_half_prev;
    set_vec[F_WAKE_IO13] = io1_wake_evt | io3_wake_evt;
    set_vec[F_WAKE_IO02] = io0_wake_evt | io2_wake_evt;
    set_vec[F_WAKE_SERIAL] = serial_wake_evt & lowpower_regulator_on_mode;
    set_vec[F_WAKE_FORCED] = forced_wake_event;
    set_vec[F_INT_TIMEOUT] = int_timeout_evt;
    set_vec[F_LP_OFF] = any_wake & lowpower_regulator_off_mode;
    set_vec[F_RESET_REQ] = serial_reset_evt;
    set_vec[F_DEBUG_EXIT] = debug_mode & state_q.debug_pin_prev & !debug_entry_pin;
  end

  // Only flags seen set in the snapshot clear, so later events survive
  assign clr_vec = read_done ? state_q.snap : '0;

  for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
    diag_flag_cell #(
      .HOLD(HOLD_MASK[i])
    ) u_cell (
      .core_clk(core_clk),
      .rstn(rstn),
      .set_in(set_vec[i]),
      .cond_in(cond_vec[i]),
      .read_clr(clr_vec[i]),
      .flag(flags[i])
    );
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign read_data = state_q.snap;

endmodule

// ### diag_flags_chk.sv
// Assertion checker for the diagnostic flag latches
`timescale 1ns/100ps
module diag_flags_chk
  import diag_flag_pkg::*;
#(
  parameter int STUCK_CYCLES = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Sources
  input wire logic canl_short_bat,
  input wire logic serial_select_n,
  input wire logic supply_two_under_threshold,
  input wire logic parity_error_evt,
  input wire logic forced_wake_event,
  input wire logic debug_mode,
  input wire logic debug_entry_pin,
  // Host read and results
  input wire logic [FLAG_COUNT-1:0] read_sel,
  input wire logic read_capture,
  input wire logic read_done,
  input wire logic [FLAG_COUNT-1:0] read_data,
  input wire logic [FLAG_COUNT-1:0] flags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Counts consecutive low select cycles, too many to unroll as a repetition
  int sel_low_cnt;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sel_low_cnt <= 0;
    end else if (serial_select_n) begin
      sel_low_cnt <= 0;
    end else if (sel_low_cnt < STUCK_CYCLES) begin
      sel_low_cnt <= sel_low_cnt + 1;
    end
  end
  property p_stuck; !serial_select_n && sel_low_cnt == STUCK_CYCLES - 1 |=> flags[F_SEL_STUCK];
  endproperty
  a_stuck: assert property (p_stuck) else $error("stuck select flag not set");
  sequence s_dbg_exit;
    debug_mode && debug_entry_pin ##1 debug_mode && !debug_entry_pin;
  endsequence
  property p_can; canl_short_bat |=> flags[F_CANL_BAT]; endproperty
  property p_hold; flags[F_SUP2_UNDER] && supply_two_under_threshold |=> flags[F_SUP2_UNDER];
  endproperty
  property p_par; parity_error_evt |=> flags[F_PARITY]; endproperty
  property p_clr; read_done && !read_capture && read_data[F_PARITY] && !parity_error_evt
    |=> !flags[F_PARITY]; endproperty
  property p_fwu; forced_wake_event |=> flags[F_WAKE_FORCED]; endproperty
  property p_stick; flags[F_WAKE_FORCED] && !read_done |=> flags[F_WAKE_FORCED]; endproperty
  property p_dbg; s_dbg_exit |=> flags[F_DEBUG_EXIT]; endproperty
  property p_snap; read_capture |=> read_data == ($past(flags) & $past(read_sel)); endproperty
  a_can: assert property (p_can) else $error("short flag not set");
  a_hold: assert property (p_hold) else $error("under flag cleared early");
  a_par: assert property (p_par) else $error("parity flag not set");
  a_clr: assert property (p_clr) else $error("parity flag not cleared");
  a_fwu: assert property (p_fwu) else $error("forced wake flag not set");
  a_stick: assert property (p_stick) else $error("event flag lost");
  a_dbg: assert property (p_dbg) else $error("debug exit flag not set");
  a_snap: assert property (p_snap) else $error("read snapshot wrong");
endmodule

bind diag_fault_wake_flags diag_flags_chk #(.STUCK_CYCLES(STUCK_CYCLES)) diag_flags_chk_i (
  .core_clk, .rstn, .canl_short_bat, .serial_select_n, .supply_two_under_threshold,
  .parity_error_evt,
  .forced_wake_event, .debug_mode, .debug_entry_pin, .read_sel, .read_capture, .read_done,
  .read_data, .flags);

// ### host_reader.sv
// Host model: snapshot strobe, a variable wait, then end of transfer
`timescale 1ns/100ps
module host_reader
  import diag_flag_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bench request
  input wire logic go,
  input wire logic [3:0] gap,
  // Read strobes
  output logic [FLAG_COUNT-1:0] read_sel,
  output logic read_capture,
  output logic read_done
);
  logic [3:0] cnt_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      read_capture <= 1'b0;
      read_done <= 1'b0;
      read_sel <= '0;
    end else begin
      // Mask only meaningful at capture; scrambled otherwise
      read_sel <= go ? '1 : ~read_sel;
      read_capture <= go;
      read_done <= (cnt_q == 4'h1);
      cnt_q <= go ? gap : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
    end
  end
endmodule

// ### diag_fault_wake_flags_tb_top.sv
// Self-checking bench for the diagnostic flag latches
`timescale 1ns/100ps
module diag_fault_wake_flags_tb_top;
  import diag_flag_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, sel_n = 1'b1, go = 1'b0, cap_q = 1'b0;
  logic [10:0] flt = '0;
  logic [8:0] pu = '0;
  logic [4:0] md = '0;
  logic [15:0] wd_e = '0, wd_p = 16'h0064;
  logic [3:0] gap = 4'h3;
  logic [1:0] r;
  logic [21:0] read_sel, read_data, flags;
  logic read_capture, read_done;
  logic [21:0] q[$];
  int seed = 13086, err_total = 0, cmp_count = 0;
  always #10 core_clk = ~core_clk;
  diag_fault_wake_flags #(.STUCK_CYCLES(20)) diag_fault_wake_flags_i (.core_clk, .rstn,
    .canl_short_bat(flt[0]), .canl_short_vdd(flt[1]), .canl_short_gnd(flt[2]),
    .canh_short_bat(flt[3]), .canh_short_vdd(flt[4]), .canh_short_gnd(flt[5]),
    .high_side_switch3_short_gnd(flt[6]), .high_side_switch2_short_gnd(flt[7]),
    .supply_two_under_threshold(flt[8]), .supply_over_threshold(flt[9]),
    .io0_thermal_over(flt[10]), .serial_select_n(sel_n), .parity_error_evt(pu[0]),
    .flash_mode(md[0]), .wd_elapsed(wd_e), .wd_period(wd_p), .io1_wake_evt(pu[1]),
    .io3_wake_evt(pu[2]), .io0_wake_evt(pu[3]), .io2_wake_evt(pu[4]),
    .serial_wake_evt(pu[5]), .lowpower_regulator_on_mode(md[1]),
    .lowpower_regulator_off_mode(md[2]), .forced_wake_event(pu[6]),
    .int_timeout_evt(pu[7]), .serial_reset_evt(pu[8]), .debug_mode(md[3]),
    .debug_entry_pin(md[4]), .read_sel, .read_capture, .read_done, .read_data, .flags);
  host_reader host_reader_i (.core_clk, .rstn, .go, .gap, .read_sel, .read_capture,
    .read_done);
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic pulse(input logic [8:0] m);
    pu <= m;
    tick(1);
    pu <= '0;
    tick(1);
  endtask
  task automatic rd(input logic [21:0] e);
    q.push_back(e);
    go <= 1'b1;
    gap <= 4'h3 + {2'h0, 2'($random(seed))};
    tick(1);
    go <= 1'b0;
    tick(9);
  endtask
  task automatic cmp(input logic [21:0] e);
    cmp_count++;
    if (read_data !== e) begin
      err_total++;
      $display("mismatch read_data expected %h seen %h", e, read_data);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Snapshot is registered at the capture edge, so look at the next falling edge
  always @(posedge core_clk) cap_q <= read_capture;
  always @(negedge core_clk) if (cap_q && q.size() > 0) cmp(q.pop_front());
  initial begin
    #40000;
    err_total++;
    print_verdict();
  end
  initial begin
    tick(12);
    rstn <= 1'b1;
    tick(1);
    md <= 5'h02;
    r = 2'($random(seed));
    pulse(9'h1E1 | (r[0] ? 9'h002 : 9'h004) | (r[1] ? 9'h008 : 9'h010));
    rd(22'h17C100);
    rd(22'h000000);
    flt <= 11'($random(seed)) | 11'h101;
    tick(2);
    rd({9'h000, flt[10:8], 2'h0, flt[7:0]});
    rd({9'h000, flt[10:8], 2'h0, flt[7:0]});
    flt <= '0;
    tick(2);
    rd(22'h000000);
    sel_n <= 1'b0;
    tick(10);
    sel_n <= 1'b1;
    tick(2);
    sel_n <= 1'b0;
    tick(25);
    sel_n <= 1'b1;
    rd(22'h000200);
    md <= 5'h01;
    wd_e <= 16'h0032;
    tick(3);
    rd(22'h000000);
    wd_e <= 16'h0033;
    tick(2);
    rd(22'h002000);
    md <= 5'h1C;
    tick(2);
    md <= 5'h0C;
    pulse(9'h040);
    rd(22'h2A0000);
    md <= 5'h00;
    q.push_back(22'h000000);
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(1);
    pulse(9'h001);
    tick(6);
    rd(22'h000100);
    print_verdict();
  end
endmodule
